// >>> src/rofm_regs.sv
`timescale 1ns/1ps
`include "rofm_defines.svh"
module rofm_regs
    import rofm_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic          reset_n_i,
    input  wire logic [7:0]    reg_addr_i,
    input  wire logic          reg_wr_i,
    input  wire logic [7:0]    reg_wdata_i,
    input  wire logic          reg_rd_i,
    output logic      [7:0]    reg_rdata_o,
    input  wire rofm_factory_t factory_i,
    input  wire logic [3:0]    pg_tree_i,
    input  wire logic [3:0]    rail_pin_req_i,
    input  wire logic [3:0]    rail_kill_n_i,
    input  wire logic [12:0]   rail_fault_i,
    output logic      [3:0]    rail_en_o,
    output logic               switch_b_two_en_o,
    output logic               aux_reg_one_en_o,
    output logic      [3:0]    gpo_out_o,
    output logic      [3:0]    gpo_oe_o,
    output logic               shutdown_req_o
);

    rofm_state_t st_ff;
    rofm_state_t nxt_st;
    logic [3:0]  gate_en_w;
    logic [12:0] fault_mask_w;
    logic [12:0] unmasked_w;
    logic [3:0]  level_w;

    // ------------------------------------------------------------------------
    // Rail enable gating
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rail
            rofm_rail_gate u_gate (
                .force_on_i (st_ff.ctrl[gi]),
                .kill_n_i   (rail_kill_n_i[gi]),
                .pin_req_i  (rail_pin_req_i[gi]),
                .enable_o   (gate_en_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Fault masking
    // ------------------------------------------------------------------------
    // mask bit layout
    assign fault_mask_w = {st_ff.mask2[4:0], st_ff.mask1};
    assign unmasked_w   = rail_fault_i & ~fault_mask_w;
    assign level_w      = st_ff.ctrl[`ROFM_LVL_MSB:`ROFM_LVL_LSB];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (!st_ff.loaded) begin
            nxt_st.loaded = 1'b1;
            nxt_st.ctrl[`ROFM_LVL_MSB:`ROFM_LVL_LSB] = factory_i.level_default;
        end
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `ROFM_OFS_CTRL: begin
                    nxt_st.ctrl = reg_wdata_i;
                end
                `ROFM_OFS_MASK1: begin
                    nxt_st.mask1 = reg_wdata_i;
                end
                `ROFM_OFS_MASK2: begin
                    nxt_st.mask2 = reg_wdata_i & `ROFM_MASK2_USED;
                end
                default: begin
                end
            endcase
        end
        nxt_st.rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `ROFM_OFS_CTRL: begin
                    nxt_st.rdata = st_ff.ctrl;
                end
                `ROFM_OFS_MASK1: begin
                    nxt_st.rdata = st_ff.mask1;
                end
                `ROFM_OFS_MASK2: begin
                    nxt_st.rdata = st_ff.mask2;
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end
        nxt_st.rail_en  = gate_en_w;
        nxt_st.shutdown = |unmasked_w;
        for (int i = 0; i < 4; i++) begin
            if (factory_i.serial[i]) begin
                if (factory_i.push_pull[i] && i != 3) begin
                    nxt_st.pins.out[i] = level_w[i];
                    nxt_st.pins.oe[i]  = 1'b1;
                end else begin
                    nxt_st.pins.out[i] = 1'b0;
                    nxt_st.pins.oe[i]  = ~level_w[i];
                end
            end else if (factory_i.push_pull[i] && i != 3) begin
                nxt_st.pins.out[i] = pg_tree_i[i];
                nxt_st.pins.oe[i]  = 1'b1;
            end else begin
                nxt_st.pins.out[i] = 1'b0;
                nxt_st.pins.oe[i]  = ~pg_tree_i[i];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff          <= '0;
            st_ff.ctrl     <= `ROFM_RST_CTRL;
            st_ff.mask1    <= `ROFM_RST_MASK1;
            st_ff.mask2    <= `ROFM_RST_MASK2;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata_o       = st_ff.rdata;
    assign rail_en_o         = st_ff.rail_en;
    assign switch_b_two_en_o = st_ff.rail_en[2] & ~factory_i.shared_is_aux;
    assign aux_reg_one_en_o  = st_ff.rail_en[2] & factory_i.shared_is_aux;
    assign gpo_out_o         = st_ff.pins.out;
    assign gpo_oe_o          = st_ff.pins.oe;
    assign shutdown_req_o    = st_ff.shutdown;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_kill_off;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !rail_kill_n_i[0] |=> !rail_en_o[0];
    endproperty
    a_kill_off: assert property (p_kill_off) else $error("killed rail stayed on");

    property p_force_on;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (st_ff.ctrl[3] && rail_kill_n_i[3]) |=> rail_en_o[3];
    endproperty
    a_force_on: assert property (p_force_on) else $error("forced rail not on");

    property p_pin_follow;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!st_ff.ctrl[1] && rail_kill_n_i[1]) |=> rail_en_o[1] == $past(rail_pin_req_i[1]);
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("rail ignored its pin");

    property p_shutdown;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        ##1 shutdown_req_o == |$past(unmasked_w);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown mismatch");

    property p_masked_quiet;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (rail_fault_i == 13'h0040 && st_ff.mask1[6]) |=> !shutdown_req_o;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked fault shut down");

    property p_unmasked_trip;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (rail_fault_i[12] && !st_ff.mask2[4]) |=> shutdown_req_o;
    endproperty
    a_unmasked_trip: assert property (p_unmasked_trip) else $error("fault not seen");

    property p_out_four;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        factory_i.serial[3] |=> (gpo_oe_o[3] == !$past(level_w[3])) && !gpo_out_o[3];
    endproperty
    a_out_four: assert property (p_out_four) else $error("out four level wrong");

    property p_pg_follow;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!factory_i.serial[0] && factory_i.push_pull[0]) |=> gpo_out_o[0] == $past(pg_tree_i[0]);
    endproperty
    a_pg_follow: assert property (p_pg_follow) else $error("out one ignored pg tree");

    property p_mask1_write;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reg_wr_i && reg_addr_i == `ROFM_OFS_MASK1) |=> st_ff.mask1 == $past(reg_wdata_i);
    endproperty
    a_mask1_write: assert property (p_mask1_write) else $error("mask1 write lost");

    property p_mask2_ro;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reg_rd_i && reg_addr_i == `ROFM_OFS_MASK2) |=> !reg_rdata_o[`ROFM_MASK2_RO_BIT];
    endproperty
    a_mask2_ro: assert property (p_mask2_ro) else $error("mask2 bit 7 not zero");

    c_forced: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        st_ff.ctrl[0] && !rail_pin_req_i[0] ##1 rail_en_o[0]);
    c_trip: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        |rail_fault_i ##1 shutdown_req_o);
    c_masked: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        |rail_fault_i && !(|unmasked_w));
    c_serial_pin: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        factory_i.serial[1] && level_w[1]);

endmodule // rofm_regs

// >>> src/rofm_defines.svh
// How it works
// - With general output four set up for serial control, bit 7 of the override register drives its open-drain pin low on 0 and releases it high on 1.
// - General outputs three, two and one take their levels from bits 6, 5 and 4 when set up for serial control, in open-drain or push-pull form.
// - A general output that is not under serial control ignores its level bit and follows its power-good tree.
// - Each output level bit resets to zero unless the factory default supplies another value.
// - A rail whose force-on bit is 0 is switched only by its control input or internal power-good request.
// - Bit 3 at 1 forces the termination regulator on unless its kill bit is 0.
// - Bit 2 at 1 forces the shared rail, routed to switch b two or aux regulator one, on unless its kill bit is 0.
// - Bit 1 at 1 forces load switch b one on unless its kill bit is 0.
// - Bit 0 at 1 forces aux regulator three on unless its kill bit is 0.
// - A rail fault whose mask bit is 1 does not cause shutdown, and with the bit at 0 it does.
// - Bit 7 of the first fault-mask register masks aux regulator two.
// - Bit 6 of the first fault-mask register masks load switch a one.
// - Bits 5 to 0 of the first fault-mask register mask step-down rails six to one.
// - Bits 4 to 0 of the second fault-mask register mask aux one, termination, switch b two, switch b one and aux three.
// - A kill bit at 0 turns its rail off whatever the force-on bit and control inputs say.
`ifndef ROFM_DEFINES_SVH
`define ROFM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ROFM_OFS_CTRL      8'hA1
`define ROFM_OFS_MASK1     8'hA2
`define ROFM_OFS_MASK2     8'hA3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ROFM_RST_CTRL      8'h00
`define ROFM_RST_MASK1     8'h00
`define ROFM_RST_MASK2     8'h20
`define ROFM_RST_LEVEL     4'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ROFM_LVL_LSB       4
`define ROFM_LVL_MSB       7
`define ROFM_FORCE_MSB     3
`define ROFM_MASK2_RO_BIT  7
`define ROFM_MASK2_USED    8'h7F

`endif

// >>> src/rofm_pkg.sv
package rofm_pkg;

    // Index order of the four gated rails: aux three, switch b one, shared, termination.
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } rofm_pins_t;

    typedef struct packed {
        logic [3:0] serial;
        logic [3:0] push_pull;
        logic [3:0] level_default;
        logic       shared_is_aux;
    } rofm_factory_t;

    typedef struct packed {
        logic       loaded;
        logic [7:0] ctrl;
        logic [7:0] mask1;
        logic [7:0] mask2;
        logic [7:0] rdata;
        logic [3:0] rail_en;
        logic       shutdown;
        rofm_pins_t pins;
    } rofm_state_t;

endpackage

// >>> src/rofm_rail_gate.sv
`timescale 1ns/1ps
module rofm_rail_gate (
    input  wire logic force_on_i,
    input  wire logic kill_n_i,
    input  wire logic pin_req_i,
    output logic      enable_o
);
    // The kill bit dominates; otherwise the force bit or the pin request turns the rail on.
    assign enable_o = kill_n_i & (force_on_i | pin_req_i);
endmodule // rofm_rail_gate

// >>> tb/rail_override_fault_mask_regs_test.sv
`timescale 1ns/1ps
module rail_override_fault_mask_regs_test;
    import rofm_pkg::*;

    logic          clk_sys_i = 1'b0;
    logic          reset_n_i = 1'b0;
    logic [7:0]    addr      = 8'h00;
    logic          wr        = 1'b0;
    logic [7:0]    wdata     = 8'h00;
    logic          rd        = 1'b0;
    logic [7:0]    rdata;
    rofm_factory_t factory   = '{4'h5, 4'h3, 4'hA, 1'b0};
    logic [3:0]    pg        = 4'h0;
    logic [3:0]    pin_req   = 4'h0;
    logic [3:0]    kill_n    = 4'hF;
    logic [12:0]   fault     = 13'h0000;
    logic [3:0]    rail_en;
    logic [3:0]    gpo_out;
    logic [3:0]    gpo_oe;
    logic          sw_b2_en;
    logic          aux1_en;
    logic          shutdown;
    int            fails      = 0;
    int            n_compared = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    rofm_regs dut_u (
        .clk_sys_i         (clk_sys_i),
        .reset_n_i         (reset_n_i),
        .reg_addr_i        (addr),
        .reg_wr_i          (wr),
        .reg_wdata_i       (wdata),
        .reg_rd_i          (rd),
        .reg_rdata_o       (rdata),
        .factory_i         (factory),
        .pg_tree_i         (pg),
        .rail_pin_req_i    (pin_req),
        .rail_kill_n_i     (kill_n),
        .rail_fault_i      (fault),
        .rail_en_o         (rail_en),
        .switch_b_two_en_o (sw_b2_en),
        .aux_reg_one_en_o  (aux1_en),
        .gpo_out_o         (gpo_out),
        .gpo_oe_o          (gpo_oe),
        .shutdown_req_o    (shutdown)
    );

    // ------------------------------------------------------------------------
    // Bus and compare tasks, all entered just after a falling edge
    // ------------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(2);
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        tick(1);
        d = rdata;
        rd = 1'b0;
        tick(1);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_registers;
        logic [7:0] d;
        reg_rd(8'hA1, d);
        chk_reg(d, 8'hA0, "control after reset");
        reg_rd(8'hA2, d);
        chk_reg(d, 8'h00, "first mask after reset");
        reg_rd(8'hA3, d);
        chk_reg(d, 8'h20, "second mask after reset");
        tick(1);
        chk_reg(rdata, 8'h00, "read data idle");
        reg_wr(8'hA2, 8'hC3);
        reg_rd(8'hA2, d);
        chk_reg(d, 8'hC3, "first mask readback");
        reg_wr(8'hA3, 8'hBF);
        reg_rd(8'hA3, d);
        chk_reg(d, 8'h3F, "second mask top bit");
        reg_wr(8'hA0, 8'hFF);
        reg_rd(8'hA0, d);
        chk_reg(d, 8'h00, "unmapped read");
        reg_rd(8'hA1, d);
        chk_reg(d, 8'hA0, "control untouched");
        reg_wr(8'hA2, 8'h00);
        reg_wr(8'hA3, 8'h20);
        $display("test registers done");
    endtask

    task automatic t_rails;
        for (int i = 0; i < 4; i++) begin
            reg_wr(8'hA1, 8'h01 << i);
            chk_reg({4'h0, rail_en}, 8'h01 << i, "force on");
            if (i == 2) begin
                chk_reg({7'h00, sw_b2_en}, 8'h01, "shared to switch");
                chk_reg({7'h00, aux1_en}, 8'h00, "shared not to aux");
                factory.shared_is_aux = 1'b1;
                tick(1);
                chk_reg({7'h00, sw_b2_en}, 8'h00, "shared not to switch");
                chk_reg({7'h00, aux1_en}, 8'h01, "shared to aux");
                factory.shared_is_aux = 1'b0;
            end
            kill_n[i] = 1'b0;
            pin_req[i] = 1'b1;
            tick(2);
            chk_reg({4'h0, rail_en}, 8'h00, "kill wins");
            kill_n[i] = 1'b1;
            reg_wr(8'hA1, 8'h00);
            chk_reg({4'h0, rail_en}, 8'h01 << i, "pin request on");
            pin_req[i] = 1'b0;
            tick(2);
            chk_reg({4'h0, rail_en}, 8'h00, "pin request off");
        end
        $display("test rails done");
    endtask

    task automatic t_outputs;
        logic [3:0] lv;
        logic [3:0] exp;
        logic [3:0] got;
        for (int p = 0; p < 2; p++) begin
            // The second pass swaps which outputs are serial, so every pin form is seen.
            factory.serial = (p == 0) ? 4'h5 : 4'hA;
            for (int v = 0; v < 16; v++) begin
                lv = ~4'(v);
                pg = 4'(v);
                reg_wr(8'hA1, {lv, 4'h0});
                exp = (lv & factory.serial) | (pg & ~factory.serial);
                got[3] = gpo_oe[3] ? gpo_out[3] : 1'b1;
                got[2] = gpo_oe[2] ? gpo_out[2] : 1'b1;
                got[1:0] = gpo_out[1:0];
                chk_reg({got, gpo_out[3:2], gpo_oe[1:0]}, {exp, 4'h3}, "pin levels");
            end
        end
        factory.serial = 4'h5;
        $display("test outputs done");
    endtask

    task automatic t_faults;
        logic [12:0] mv;
        for (int i = 0; i < 13; i++) begin
            fault = 13'h0001 << i;
            tick(2);
            chk_reg({7'h00, shutdown}, 8'h01, "unmasked fault");
            mv = 13'h0001 << i;
            reg_wr(8'hA2, mv[7:0]);
            reg_wr(8'hA3, {3'b001, mv[12:8]});
            chk_reg({7'h00, shutdown}, 8'h00, "masked fault");
            reg_wr(8'hA2, 8'h00);
            reg_wr(8'hA3, 8'h20);
        end
        fault = 13'h0000;
        $display("test faults done");
    endtask

    // ------------------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        fails++;
        $display("BAD %0t run did not end in time", $time);
        tally_and_finish();
    end

    initial begin
        tick(3);
        reset_n_i = 1'b1;
        tick(2);
        t_registers();
        t_rails();
        t_outputs();
        t_faults();
        tally_and_finish();
    end
endmodule // rail_override_fault_mask_regs_test
